// File: src/pcw_map.svh
// Bit positions, field widths and reset values of the channel control word
`ifndef PCW_MAP_SVH
`define PCW_MAP_SVH
`define PCW_WORD_W 29
`define PCW_DIR_BIT 28
`define PCW_SEL_HI 27
`define PCW_SEL_LO 24
`define PCW_REGSEL_HI 23
`define PCW_REGSEL_LO 22
`define PCW_ON_BIT 21
`define PCW_FORCE_HI 20
`define PCW_FORCE_LO 19
`define PCW_RSVD_BIT 18
`define PCW_RANGE_HI 17
`define PCW_RANGE_LO 15
`define PCW_MEAS_HI 14
`define PCW_MEAS_LO 13
`define PCW_FORCE_IN_BIT 12
`define PCW_SF_BIT 11
`define PCW_SS_BIT 10
`define PCW_CLAMP_BIT 9
`define PCW_CPOL_BIT 8
`define PCW_CMPVI_BIT 7
`define PCW_CLR_BIT 6
`define PCW_RST_RANGE 3'h3
`define PCW_RST_FORCE 2'h0
`define PCW_RST_MEAS 2'h0
`define PCW_NUM_CHAN 4
`endif

// File: src/pcw_pkg.sv
// Types shared by the channel control word decoder
package pcw_pkg;
    typedef enum logic [1:0] {
        PCW_VFORCE_ICLAMP = 2'h0,
        PCW_IFORCE_VCLAMP = 2'h1,
        PCW_HIZ_V = 2'h2,
        PCW_HIZ_I = 2'h3
    } pcw_force_t;

    typedef enum logic [2:0] {
        PCW_R_5UA = 3'h0,
        PCW_R_20UA = 3'h1,
        PCW_R_200UA = 3'h2,
        PCW_R_2MA = 3'h3,
        PCW_R_EXT = 3'h4,
        PCW_R_BUF_OFF = 3'h5,
        PCW_R_BUF_ON = 3'h6,
        PCW_R_RSVD = 3'h7
    } pcw_range_t;

    // Stored per-channel settings
    typedef struct packed {
        logic channel_on;
        pcw_force_t force_mode;
        pcw_range_t range;
        logic [1:0] measure_sel;
        logic force_input_select;
        logic system_force_switch;
        logic system_sense_switch;
        logic clamp_on;
        logic clamp_polarity;
        logic compare_vi;
    } pcw_chan_cfg_t;

    // Derived analogue controls per channel
    typedef struct packed {
        logic output_switch_two;
        logic output_switch_five;
        logic voltage_forcing;
        logic current_clamp_active;
        logic voltage_clamp_active;
        logic level_preload;
    } pcw_chan_drive_t;

    typedef enum logic [1:0] {
        PCW_ST_IDLE = 2'b01,
        PCW_ST_READ = 2'b10
    } pcw_state_t;
endpackage

// File: src/pcw_chan.sv
// One measurement channel: stored control settings and derived switch drives
`timescale 1ns/1ps
`include "pcw_map.svh"
module pcw_chan (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Write request for this channel
    input wire logic wr_en,
    input wire logic clear_req,
    input wire pcw_pkg::pcw_chan_cfg_t wr_cfg,
    // State
    output pcw_pkg::pcw_chan_cfg_t cfg_ff,
    output pcw_pkg::pcw_chan_drive_t drive_ff
);
    import pcw_pkg::*;

    pcw_chan_cfg_t nxt_cfg;

    // Unselected channels hold every setting
    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr_en) begin
            nxt_cfg = wr_cfg;
        end
    end

    // Settings register; a clear write stores its word like any write and holds level preload off for that one edge only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_ff <= '{channel_on: 1'b0, force_mode: pcw_force_t'(`PCW_RST_FORCE),
                        range: pcw_range_t'(`PCW_RST_RANGE), measure_sel: `PCW_RST_MEAS,
                        default: 1'b0};
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // Switch drives are taken from the next settings, so they change on the same edge as the stored settings
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive_ff <= '{output_switch_two: 1'b1, default: 1'b0};
        end else begin
            // Disabled channel: switch two closed, five open, outputs high-Z
            drive_ff.output_switch_two <= ~nxt_cfg.channel_on;
            drive_ff.output_switch_five <= nxt_cfg.channel_on;
            drive_ff.voltage_forcing <= nxt_cfg.channel_on
                && nxt_cfg.force_mode == PCW_VFORCE_ICLAMP;
            // Current clamp only in voltage-force mode with clamp enabled, whether the channel is on or off
            drive_ff.current_clamp_active <= nxt_cfg.force_mode == PCW_VFORCE_ICLAMP
                && nxt_cfg.clamp_on;
            drive_ff.voltage_clamp_active <= nxt_cfg.force_mode == PCW_IFORCE_VCLAMP
                && nxt_cfg.clamp_on;
            // High-Z modes keep level converters loading new codes
            drive_ff.level_preload <= nxt_cfg.force_mode[1] && !clear_req;
        end
    end
endmodule

// File: src/pcw_ctrl.sv
// Decoder of the per-channel control word for a quad measurement unit
`timescale 1ns/1ps
`include "pcw_map.svh"
module pcw_ctrl #(
    parameter int NUM_CHAN = `PCW_NUM_CHAN
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Command word from the serial front end, same clock domain
    input wire logic word_valid,
    input wire logic [`PCW_WORD_W-1:0] word_data,
    // First-stage level codes arriving for each channel
    input wire logic [NUM_CHAN-1:0] first_stage_code_valid,
    // Readback request toward the serial front end
    output logic readback_start_ff,
    output logic [`PCW_WORD_W-1:0] readback_word_ff,
    output logic [NUM_CHAN-1:0] readback_chan_ff,
    // Per-channel state and drives
    output pcw_pkg::pcw_chan_cfg_t [NUM_CHAN-1:0] chan_cfg,
    output pcw_pkg::pcw_chan_drive_t [NUM_CHAN-1:0] chan_drive,
    output logic [NUM_CHAN-1:0] level_load_ff
);
    import pcw_pkg::*;

    logic regsel_hit;
    logic is_write;
    logic is_read;
    logic [NUM_CHAN-1:0] chan_select;
    pcw_chan_cfg_t word_cfg;
    pcw_state_t state_ff;
    pcw_state_t nxt_state;

    // Register select must be zero for the channel register
    assign regsel_hit = !word_data[`PCW_REGSEL_HI] && !word_data[`PCW_REGSEL_LO];
    assign is_write = word_valid && regsel_hit && !word_data[`PCW_DIR_BIT];
    assign is_read = word_valid && word_data[`PCW_DIR_BIT];
    // Select flags, channel 0 at the lowest bit
    assign chan_select = word_data[`PCW_SEL_LO +: NUM_CHAN];

    // Field extraction; bit 18 and bits 5:0 are not looked at, so junk there is harmless
    always_comb begin
        word_cfg.channel_on = word_data[`PCW_ON_BIT];
        word_cfg.force_mode = pcw_force_t'(word_data[`PCW_FORCE_HI:`PCW_FORCE_LO]);
        word_cfg.range = pcw_range_t'(word_data[`PCW_RANGE_HI:`PCW_RANGE_LO]);
        word_cfg.measure_sel = word_data[`PCW_MEAS_HI:`PCW_MEAS_LO];
        word_cfg.force_input_select = word_data[`PCW_FORCE_IN_BIT];
        word_cfg.system_force_switch = word_data[`PCW_SF_BIT];
        word_cfg.system_sense_switch = word_data[`PCW_SS_BIT];
        word_cfg.clamp_on = word_data[`PCW_CLAMP_BIT];
        word_cfg.clamp_polarity = word_data[`PCW_CPOL_BIT];
        word_cfg.compare_vi = word_data[`PCW_CMPVI_BIT];
    end

    // Per-channel storage; all selected channels update in the same cycle
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        pcw_chan u_chan (
            .clock(clock),
            .rst(rst),
            .wr_en(is_write && chan_select[c]),
            .clear_req(is_write && chan_select[c] && word_data[`PCW_CLR_BIT]),
            .wr_cfg(word_cfg),
            .cfg_ff(chan_cfg[c]),
            .drive_ff(chan_drive[c])
        );

        // Level codes pass through in any force mode, high-Z included
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                level_load_ff[c] <= 1'b0;
            end else begin
                level_load_ff[c] <= first_stage_code_valid[c];
            end
        end
    end

    // Readback sequencer: one pulse per read word
    always_comb begin
        case (state_ff)
            PCW_ST_IDLE: nxt_state = is_read ? PCW_ST_READ : PCW_ST_IDLE;
            PCW_ST_READ: nxt_state = is_read ? PCW_ST_READ : PCW_ST_IDLE;
            default: nxt_state = PCW_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= PCW_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Readback handoff: the front end decodes the address bits itself
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readback_start_ff <= 1'b0;
            readback_word_ff <= '0;
            readback_chan_ff <= '0;
        end else begin
            readback_start_ff <= is_read;
            if (is_read) begin
                readback_word_ff <= word_data;
                readback_chan_ff <= chan_select;
            end
        end
    end
endmodule

// File: bench/pcw_checker.sv
// Assertion checker for the channel control word decoder
`timescale 1ns/1ps
`include "pcw_map.svh"
module pcw_checker #(
    parameter int NUM_CHAN = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Command side
    input wire logic word_valid,
    input wire logic [`PCW_WORD_W-1:0] word_data,
    input wire logic [NUM_CHAN-1:0] first_stage_code_valid,
    // Results
    input wire logic readback_start_ff,
    input wire logic [`PCW_WORD_W-1:0] readback_word_ff,
    input wire logic [NUM_CHAN-1:0] readback_chan_ff,
    input wire pcw_pkg::pcw_chan_cfg_t [NUM_CHAN-1:0] chan_cfg,
    input wire pcw_pkg::pcw_chan_drive_t [NUM_CHAN-1:0] chan_drive,
    input wire logic [NUM_CHAN-1:0] level_load_ff
);
    import pcw_pkg::*;
    logic wr;
    logic rd;
    logic [`PCW_WORD_W-1:0] last_w;
    // Decoded requests
    assign rd = word_valid && word_data[28];
    assign wr = word_valid && !word_data[28] && word_data[23:22] == 2'h0;
    // Word of the previous edge, so results can be tied to their cause
    always_ff @(posedge clock) last_w <= word_data;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_rb_pulse: assert property (rd |=> readback_start_ff && readback_word_ff == last_w)
        else $error("readback missing");
    a_rb_only: assert property (!rd |=> !readback_start_ff)
        else $error("stray readback");
    a_cfg_hold: assert property (!wr |=> $stable(chan_cfg))
        else $error("settings changed without write");
    a_unsel_keep: assert property (wr && !word_data[24] |=> $stable(chan_cfg[0]))
        else $error("unselected channel changed");
    a_sel_on: assert property (wr && word_data[24] |=> chan_cfg[0].channel_on == last_w[21])
        else $error("enable not applied");
    a_sel_fields: assert property (wr && word_data[27] |=>
        chan_cfg[3].force_mode == last_w[20:19] && chan_cfg[3].measure_sel == last_w[14:13])
        else $error("fields not applied");
    a_off_hiz: assert property (!chan_cfg[0].channel_on |->
        chan_drive[0].output_switch_two && !chan_drive[0].output_switch_five)
        else $error("disabled channel not high-Z");
    a_level_load: assert property (first_stage_code_valid[0] |=> level_load_ff[0])
        else $error("level code not passed");
    c_bcast: cover property (wr && word_data[27:24] == 4'hf);
    c_read: cover property (rd);
    c_hiz: cover property (chan_cfg[3].force_mode == PCW_HIZ_I);
endmodule
bind pcw_ctrl pcw_checker #(.NUM_CHAN(NUM_CHAN)) u_pcw_checker (.clock(clock), .rst(rst),
    .word_valid(word_valid), .word_data(word_data),
    .first_stage_code_valid(first_stage_code_valid), .readback_start_ff(readback_start_ff),
    .readback_word_ff(readback_word_ff), .readback_chan_ff(readback_chan_ff),
    .chan_cfg(chan_cfg), .chan_drive(chan_drive), .level_load_ff(level_load_ff));

// File: bench/pcw_host.sv
// Host model that sends command words to the decoder
`timescale 1ns/1ps
`include "pcw_map.svh"
module pcw_host (
    // Clock
    input wire logic clock,
    // Command word out
    output logic word_valid,
    output logic [`PCW_WORD_W-1:0] word_data
);
    initial begin
        word_valid = 1'b0;
        word_data = '0;
    end
    // One word per call; afterwards the bus shows the inverse, never a stale copy
    task automatic put(input logic [`PCW_WORD_W-1:0] w);
        logic [`PCW_WORD_W-1:0] m;
        m = w & 29'h1ffbffc0;
        @(posedge clock);
        word_valid <= 1'b1;
        word_data <= m;
        @(posedge clock);
        word_valid <= 1'b0;
        word_data <= ~m;
    endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the channel control word decoder
`timescale 1ns/1ps
`include "pcw_map.svh"
module tb;
    import pcw_pkg::*;
    logic clock;
    logic rst;
    logic word_valid;
    logic [28:0] word_data;
    logic [3:0] fsc;
    logic rb_start;
    logic [28:0] rb_word;
    logic [3:0] rb_chan;
    pcw_chan_cfg_t [3:0] cfg;
    pcw_chan_drive_t [3:0] drv;
    logic [3:0] lvl;
    int fail_count = 0;
    int num_checks = 0;
    pcw_host u_pcw_host (.clock(clock), .word_valid(word_valid), .word_data(word_data));
    pcw_ctrl u_pcw_ctrl (.clock(clock), .rst(rst), .word_valid(word_valid),
        .word_data(word_data), .first_stage_code_valid(fsc), .readback_start_ff(rb_start),
        .readback_word_ff(rb_word), .readback_chan_ff(rb_chan), .chan_cfg(cfg),
        .chan_drive(drv), .level_load_ff(lvl));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Word builder in bus order; bit 18 and bits 5:0 stay zero
    function automatic logic [28:0] mk(logic rd, logic [3:0] sel, logic [1:0] rs, logic on,
        logic [1:0] f, logic [2:0] r, logic [1:0] m, logic [6:0] lo);
        return {rd, sel, rs, on, f, 1'b0, r, m, lo, 6'h0};
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Sends a word and lets the taking edge settle
    task automatic send(logic [28:0] w);
        u_pcw_host.put(w);
        #1;
    endtask
    // Watchdog: the tests need well under 100 cycles
    initial begin
        repeat (500) @(posedge clock);
        fail_count++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        fsc = 4'h0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(cfg[0].range, 3'h3);
        chk(drv[0].output_switch_two, 1'b1);
        $display("test reset done");
        send(mk(0, 4'h5, 2'h0, 1, 2'h0, 3'h3, 2'h2, 7'h08));
        chk({cfg[2].channel_on, cfg[0].channel_on}, 2'h3);
        chk(cfg[1].channel_on, 1'b0);
        chk(cfg[0].measure_sel, 2'h2);
        chk({drv[2].voltage_forcing, drv[2].current_clamp_active}, 2'h3);
        chk(drv[0].output_switch_five, 1'b1);
        send(mk(0, 4'hf, 2'h1, 0, 2'h0, 3'h0, 2'h0, 7'h0));
        chk(cfg[0].channel_on, 1'b1);
        send(mk(0, 4'hf, 2'h0, 0, 2'h0, 3'h3, 2'h3, 7'h0));
        chk({cfg[1].measure_sel, cfg[0].measure_sel}, 4'hf);
        chk({drv[0].output_switch_two, drv[0].output_switch_five}, 2'h2);
        $display("test enable done");
        for (int i = 0; i < 4; i++) begin
            send(mk(0, 4'h8, 2'h0, 1, i[1:0], i[2:0], 2'h1, 7'h0));
            chk(cfg[3].force_mode, i[1:0]);
            chk(cfg[3].range, i[2:0]);
            chk(cfg[0].force_mode, 2'h0);
        end
        @(posedge clock);
        fsc <= 4'h9;
        @(posedge clock);
        fsc <= 4'h0;
        #1;
        chk(lvl, 4'h9);
        chk(drv[3].level_preload, 1'b1);
        $display("test modes done");
        send(mk(1, 4'h2, 2'h1, 1, 2'h1, 3'h0, 2'h3, 7'h0));
        chk(rb_start, 1'b1);
        chk(rb_word, mk(1, 4'h2, 2'h1, 1, 2'h1, 3'h0, 2'h3, 7'h0));
        chk(rb_chan, 4'h2);
        chk(cfg[1].range, 3'h3);
        @(posedge clock);
        #1;
        chk(rb_start, 1'b0);
        $display("test readback done");
        // Low control bits and the voltage clamp path on channel 1
        send(mk(0, 4'h2, 2'h0, 1, 2'h1, 3'h2, 2'h0, 7'h7e));
        chk(cfg[1].range, 3'h2);
        chk(cfg[1][5:0], 6'h3f);
        chk(drv[1], 6'h12);
        // A clear write in high-Z voltage mode holds off preload for one cycle
        send(mk(0, 4'h4, 2'h0, 0, 2'h2, 3'h3, 2'h0, 7'h01));
        chk(cfg[2].force_mode, 2'h2);
        chk(drv[2].level_preload, 1'b0);
        @(posedge clock);
        #1;
        chk(drv[2].level_preload, 1'b1);
        $display("test fields done");
        // Reset again in mid-run
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        chk({cfg[1].channel_on, cfg[1].range}, 4'h3);
        chk(drv[1].output_switch_two, 1'b1);
        $display("test second reset done");
        give_verdict();
    end
endmodule
